// [shared/atl_pkg.sv]
package atl_pkg;

    // ****************************************
    // clocking and phase tick
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PA_PERIOD_NS  = 100;
    localparam int PA_DIV_W      = 16;
    // phase tick divide count derived from the two periods
    localparam logic [PA_DIV_W-1:0] PA_DIV_RST =
        PA_DIV_W'(PA_PERIOD_NS / CLK_PERIOD_NS);

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'hc;

    // ctrl fields
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_GATE_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // status fields
    localparam int STAT_STAGE1_BIT = 0;
    localparam int STAT_HELD_BIT   = 1;
    localparam int STAT_RAMP_BIT   = 2;
    localparam int STAT_BLOCK_BIT  = 3;

    // accepted trigger counter
    localparam int CNT_W = 16;

endpackage

// [hw/atl_tick_div.sv]
`timescale 1ns/1ps

// ****************************************
// phase accumulator tick divider
// ****************************************
module atl_tick_div
    import atl_pkg::*;
#(
    parameter int W = PA_DIV_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] period,
    output logic              tick
);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    wire          at_zero;
    wire  [W-1:0] reload;

    // a period of zero behaves as one, so the tick never stops
    assign reload  = (period == '0) ? '0 : period - W'(1);
    assign at_zero = (cnt_ff == '0);
    assign nxt_cnt = at_zero ? reload : cnt_ff - W'(1);
    assign tick    = at_zero;

    // down counter, restarts from period minus one on each tick
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule

// [hw/atl_trigger_latch.sv]
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps

// Behaviour
// - either trigger input rising gives one event
// - held pulse lasts exactly one tick interval
// - ramp output is held pulse or end flag
// - stage one captures only while block_n high
// - next tick copies stage one into stage two
// - set stage two forces stage one clear
// - following tick drops pulse, releases clear
// - stage one fall fires, gated by allow/gate
// - gated one-shot pulses divider clear low
// - undriven restart input reads as low
module atl_trigger_latch
    import atl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    // trigger inputs
    input  wire logic              selected_trigger_source,
    input  wire logic              restart_hold,
    input  wire logic              restart_hold_driven,
    input  wire logic              trigger_block_n,
    input  wire logic              end_of_waveform,
    // outputs toward sequencer and synthesizer
    output logic                   pa_tick,
    output logic                   held_trigger,
    output logic                   ramp_to_start,
    output logic                   divider_clear_n
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic atl_rise(input logic cur,
                                      input logic prev);
        atl_rise = cur & ~prev;
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    logic [1:0]          ctrl_ff;
    logic [PA_DIV_W-1:0] period_ff;
    logic [CNT_W-1:0]    count_ff;
    logic                src_prev_ff;
    logic                rh_prev_ff;
    logic                stage1_ff;
    logic                stage2_ff;
    logic                s1_prev_ff;
    logic                clear_n_ff;
    logic                ack_ff;
    logic [DATA_W-1:0]   rdata_ff;

    logic                nxt_stage1;
    logic                nxt_stage2;
    logic                nxt_clear_n;
    logic [DATA_W-1:0]   nxt_rdata;

    wire                 synth_sync_allow;
    wire                 divider_gate_ctrl;
    wire                 rh_level;
    wire                 src_rise;
    wire                 rh_rise;
    wire                 trig_evt;
    wire                 stage1_eff;
    wire                 stage1_fall;
    wire                 div_fire;
    wire                 bus_req;
    wire                 bus_take;
    wire                 wr_take;
    wire                 sel_ctrl;
    wire                 sel_period;
    wire                 sel_status;
    wire                 sel_count;
    wire [DATA_W-1:0]    status_word;

    assign synth_sync_allow  = ctrl_ff[CTRL_SYNC_BIT];
    assign divider_gate_ctrl = ctrl_ff[CTRL_GATE_BIT];

    // ****************************************
    // phase accumulator tick
    // ****************************************
    atl_tick_div #(
        .W      (PA_DIV_W)
    ) u_tick (
        .clk    (clk),
        .rst    (rst),
        .period (period_ff),
        .tick   (pa_tick)
    );

    // ****************************************
    // trigger combine
    // ****************************************
    // undriven pin sense forces the restart level low
    assign rh_level = restart_hold & restart_hold_driven;
    assign src_rise = atl_rise(selected_trigger_source, src_prev_ff);
    assign rh_rise  = atl_rise(rh_level, rh_prev_ff);
    assign trig_evt = src_rise | rh_rise;

    // input history for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            src_prev_ff <= 1'b0;
            rh_prev_ff  <= 1'b0;
        end else begin
            src_prev_ff <= selected_trigger_source;
            rh_prev_ff  <= rh_level;
        end
    end

    // ****************************************
    // two-stage trigger latch
    // ****************************************
    // stage two masks stage one at once, as the direct clear did
    assign stage1_eff = stage1_ff & ~stage2_ff;

    // stage one: clear dominates, inhibit leaves it unchanged
    always_comb begin
        nxt_stage1 = stage1_ff;
        if (stage2_ff) begin
            nxt_stage1 = 1'b0;
        end else if (trig_evt && trigger_block_n) begin
            nxt_stage1 = 1'b1;
        end
    end

    // stage two moves only on the phase tick
    assign nxt_stage2 = pa_tick ? stage1_eff : stage2_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    // held pulse spans one tick interval
    assign held_trigger  = stage2_ff;
    // combinational so the end flag reaches the sequencer at once
    assign ramp_to_start = stage2_ff | end_of_waveform;

    // ****************************************
    // divider clear one-shot
    // ****************************************
    assign stage1_fall = s1_prev_ff & ~stage1_eff;
    assign div_fire    = stage1_fall & synth_sync_allow
                         & divider_gate_ctrl;
    assign nxt_clear_n = ~div_fire;

    // one clock low pulse, registered for a clean edge
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_prev_ff <= 1'b0;
            clear_n_ff <= 1'b1;
        end else begin
            s1_prev_ff <= stage1_eff;
            clear_n_ff <= nxt_clear_n;
        end
    end
    assign divider_clear_n = clear_n_ff;

    // accepted trigger tally, wraps silently
    always_ff @(posedge clk) begin
        if (rst) begin
            count_ff <= '0;
        end else if (pa_tick && stage1_eff) begin
            count_ff <= count_ff + CNT_W'(1);
        end
    end

    // ****************************************
    // avalon-mm slave
    // ****************************************
    // one wait state: first cycle registers read data
    assign bus_req    = avs_read | avs_write;
    assign bus_take   = bus_req & ack_ff;
    assign wr_take    = bus_take & avs_write;
    assign avs_waitrequest = bus_req & ~ack_ff;

    assign sel_ctrl   = (avs_address == OFS_CTRL);
    assign sel_period = (avs_address == OFS_PERIOD);
    assign sel_status = (avs_address == OFS_STATUS);
    assign sel_count  = (avs_address == OFS_COUNT);

    assign status_word = DATA_W'({trigger_block_n, ramp_to_start,
                                  stage2_ff, stage1_eff});

    // unmapped offsets read as zero
    always_comb begin
        nxt_rdata = '0;
        if (sel_ctrl) begin
            nxt_rdata = DATA_W'(ctrl_ff);
        end else if (sel_period) begin
            nxt_rdata = DATA_W'(period_ff);
        end else if (sel_status) begin
            nxt_rdata = status_word;
        end else if (sel_count) begin
            nxt_rdata = DATA_W'(count_ff);
        end
    end

    // handshake and read capture
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff   <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff   <= bus_req & ~ack_ff;
            rdata_ff <= nxt_rdata;
        end
    end
    assign avs_readdata = rdata_ff;

    // controller settings; writes to unmapped offsets dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff   <= CTRL_RST;
            period_ff <= PA_DIV_RST;
        end else if (wr_take && sel_ctrl) begin
            ctrl_ff   <= avs_writedata[CTRL_GATE_BIT:CTRL_SYNC_BIT];
        end else if (wr_take && sel_period) begin
            period_ff <= avs_writedata[PA_DIV_W-1:0];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_src_event: assert property (
        $rose(selected_trigger_source) |-> trig_evt)
        else $error("source rise gave no trigger event");

    a_stage_capture: assert property (
        trig_evt && trigger_block_n && !stage2_ff |=> stage1_ff)
        else $error("enabled trigger not captured");

    a_inhibit_holds: assert property (
        trig_evt && !trigger_block_n && !stage2_ff
        |=> stage1_ff == $past(stage1_ff))
        else $error("blocked trigger changed stage one");

    a_stage_two_set: assert property (
        $rose(stage2_ff) |-> $past(pa_tick) && $past(stage1_eff))
        else $error("held pulse rose without tick and stage one");

    a_held_between: assert property (
        stage2_ff && !pa_tick |=> stage2_ff)
        else $error("held pulse dropped between ticks");

    a_held_drops: assert property (
        stage2_ff && pa_tick |=> !stage2_ff && !stage1_ff)
        else $error("held pulse longer than one interval");

    a_clear_hold: assert property (
        $rose(stage2_ff) |-> !stage1_eff ##1 !stage1_ff)
        else $error("stage one not cleared by stage two");

    a_ramp_or: assert property (
        ramp_to_start == (end_of_waveform || held_trigger))
        else $error("ramp differs from held pulse or end flag");

    a_div_pulse: assert property (
        $fell(stage1_eff) && synth_sync_allow && divider_gate_ctrl
        |=> !divider_clear_n ##1 divider_clear_n)
        else $error("divider clear pulse missing or long");

    a_div_gated: assert property (
        !synth_sync_allow || !divider_gate_ctrl |=> divider_clear_n)
        else $error("divider cleared while gated off");

    a_rh_undriven: assert property (
        !restart_hold_driven && !src_rise |-> !trig_evt)
        else $error("undriven restart input made a trigger");

    a_reset_clear: assert property (
        disable iff (1'b0)
        rst |=> !stage1_ff && !stage2_ff && divider_clear_n)
        else $error("stages not clear after reset");

    a_bus_wait: assert property (
        bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held beyond one cycle");

    c_held: cover property ($rose(held_trigger));
    c_div_clear: cover property ($fell(divider_clear_n));
    c_blocked: cover property (trig_evt && !trigger_block_n);
    c_bus_read: cover property (avs_read && !avs_waitrequest);

endmodule

// [verification/atl_far_model.sv]
`timescale 1ns/1ps

// ****************************************
// far side: sequence counter and divider
// ****************************************
module atl_far_model
    import atl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pa_tick,
    input  wire logic       held_trigger,
    input  wire logic       ramp_to_start,
    input  wire logic       divider_clear_n,
    input  wire logic [2:0] sel,
    output logic      [3:0] seq_cnt_ff,
    output logic      [7:0] clr_cnt_ff
);
    // count enable picked by selector code: 0 ramp, 4 held, 3 always, rest never
    wire logic cnt_en = (sel == 3'h0) ? ramp_to_start :
                        (sel == 3'h4) ? held_trigger :
                        (sel == 3'h3);
    // counter steps only on tick; each low cycle clears the divider
    always_ff @(posedge clk) begin
        if (rst) begin
            seq_cnt_ff <= 4'h0;
            clr_cnt_ff <= 8'h0;
        end else begin
            if (pa_tick && cnt_en)
                seq_cnt_ff <= seq_cnt_ff + 4'h1;
            if (!divider_clear_n)
                clr_cnt_ff <= clr_cnt_ff + 8'h1;
        end
    end
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps

module testbench;
    import atl_pkg::*;

    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = 4'h0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = 32'h0;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              src = 1'b0;
    logic              rh = 1'b0;
    logic              rh_drv = 1'b1;
    logic              block_n = 1'b1;
    logic              eow = 1'b0;
    logic              pa_tick, held, ramp, clr_n;
    logic [2:0]        sel = 3'h0;
    logic [3:0]        seq_cnt;
    logic [7:0]        clr_cnt;
    logic [DATA_W-1:0] rd;
    int                errors = 0;
    int                cmp_count = 0;
    int                n_acc = 0;

    always #5 clk = ~clk;

    atl_trigger_latch dut_u (.clk(clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .selected_trigger_source(src), .restart_hold(rh),
        .restart_hold_driven(rh_drv), .trigger_block_n(block_n),
        .end_of_waveform(eow), .pa_tick(pa_tick), .held_trigger(held),
        .ramp_to_start(ramp), .divider_clear_n(clr_n));

    atl_far_model far_u (.clk(clk), .rst(rst), .pa_tick(pa_tick),
        .held_trigger(held), .ramp_to_start(ramp),
        .divider_clear_n(clr_n), .sel(sel), .seq_cnt_ff(seq_cnt),
        .clr_cnt_ff(clr_cnt));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // request held until waitrequest is sampled low
    task automatic bus(logic wr, logic [ADDR_W-1:0] a, logic [31:0] wd);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        // only the watchdog ends a wait that never sees an answer
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // one-cycle rising edge on the chosen trigger input
    task automatic fire(int which);
        @(posedge clk);
        if (which == 0)
            src <= 1'b1;
        else
            rh <= 1'b1;
        @(posedge clk);
        src <= 1'b0;
        rh  <= 1'b0;
    endtask

    // watch 30 cycles: held width, clear pulses, ramp relation
    task automatic measure(output int w, output int c);
        w = 0;
        c = 0;
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            #1;
            w += (held === 1'b1);
            c += (clr_n === 1'b0);
            chk("ramp", ramp, held | eow);
        end
        // end on an edge so the next stimulus lands on it
        @(posedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        chk("held rst", held, 1'b0);
        chk("clr rst", clr_n, 1'b1);
        bus(1'b0, OFS_PERIOD, 32'h0);
        chk("period rst", rd, 32'(PA_DIV_RST));
        bus(1'b1, OFS_PERIOD, 32'h3);
        bus(1'b0, OFS_PERIOD, 32'h0);
        chk("period", rd, 32'h3);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status idle", rd, 32'(1 << STAT_BLOCK_BIT));
    endtask

    task automatic t_edges();
        int w, c;
        for (int k = 0; k < 2; k++) begin
            fire(k);
            measure(w, c);
            n_acc++;
            chk("width", w, 3);
        end
        rh_drv <= 1'b0;
        fire(1);
        measure(w, c);
        chk("undriven", w, 0);
        rh_drv  <= 1'b1;
        block_n <= 1'b0;
        fire(0);
        measure(w, c);
        chk("blocked", w, 0);
        block_n <= 1'b1;
        eow     <= 1'b1;
        @(posedge clk);
        #1;
        chk("ramp eow", ramp, 1'b1);
        @(posedge clk);
        eow <= 1'b0;
    endtask

    // edge while held is high must be lost, not queued
    task automatic t_merge();
        int w, c, n;
        n = 0;
        fire(0);
        n_acc++;
        while (held !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("merge held", held, 1'b1);
        fire(0);
        measure(w, c);
        chk("merged", w, 0);
    endtask

    task automatic t_divider();
        int w, c;
        logic [7:0] c0;
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, OFS_CTRL, 32'(m));
            bus(1'b0, OFS_CTRL, 32'h0);
            chk("ctrl", rd, 32'(m));
            c0 = clr_cnt;
            fire(0);
            measure(w, c);
            n_acc++;
            chk("clear", c, 32'(m == 3));
            chk("div", 8'(clr_cnt - c0), 8'(m == 3));
        end
    endtask

    task automatic t_seq();
        int w, c;
        logic [3:0] s0;
        logic [2:0] codes[3] = '{3'h4, 3'h0, 3'h5};
        for (int k = 0; k < 3; k++) begin
            sel <= codes[k];
            @(posedge clk);
            s0 = seq_cnt;
            fire(0);
            measure(w, c);
            n_acc++;
            chk("seq", 4'(seq_cnt - s0), 4'(k < 2));
        end
        bus(1'b0, OFS_COUNT, 32'h0);
        chk("count", rd, 32'(n_acc));
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_edges();
        t_merge();
        t_divider();
        t_seq();
        close_out();
    end

    // far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        errors++;
        close_out();
    end
endmodule
